// file: verilog/simd_word_permute_unit.sv
// simd word permute, mask, interleave, move and convert datapath
`timescale 1ns/1ps
module simd_word_permute_unit
    import permute_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rstn,
    input  wire logic     req_valid,
    input  wire request_t req,
    output logic          res_valid,
    output result_t       res
);
    localparam int RES_W = WIDE_W + INT_W + 1;

    // refuse package widths and a LATENCY that the fixed lane slicing and single result stage cannot serve
    if (WIDE_W != 2 * NARROW_W) begin : g_bad_halves
        $error("simd_word_permute_unit: wide register must be two narrow halves");
    end
    if (NARROW_W != 4 * LANE_W || WIDE_W != 4 * DW_W) begin : g_bad_lanes
        $error("simd_word_permute_unit: four words per half and four dwords per register");
    end
    if (NARROW_MASK * BYTE_W != NARROW_W || WIDE_MASK * BYTE_W != WIDE_W) begin : g_bad_mask
        $error("simd_word_permute_unit: one mask bit per source byte");
    end
    if (IMM_W != 4 * SEL_W) begin : g_bad_imm
        $error("simd_word_permute_unit: immediate holds four two-bit selectors");
    end
    if (INT_W != DW_W || DW_W != 2 * WIDE_MASK) begin : g_bad_int
        $error("simd_word_permute_unit: integer side must be one 32-bit dword");
    end
    if (LATENCY != 1) begin : g_bad_latency
        $error("simd_word_permute_unit: exactly one result register stage");
    end

    // pick one 16-bit word of a 64-bit group by a 2-bit index
    function automatic logic [LANE_W-1:0] pick_word(input logic [NARROW_W-1:0] g, input logic [SEL_W-1:0] s);
        pick_word = g[s*LANE_W +: LANE_W];
    endfunction : pick_word

    // four-word shuffle of a 64-bit group by the 8-bit immediate
    function automatic logic [NARROW_W-1:0] shuffle4w(input logic [NARROW_W-1:0] g, input logic [IMM_W-1:0] imm);
        logic [NARROW_W-1:0] r;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            r[i*LANE_W +: LANE_W] = pick_word(g, imm[i*SEL_W +: SEL_W]);
        end
        shuffle4w = r;
    endfunction : shuffle4w

    // single precision to signed 32-bit integer, truncating
    function automatic logic [DW_W-1:0] f2i(input logic [DW_W-1:0] f);
        logic [FLT_EXP_W-1:0] e;
        logic [63:0]          m;
        logic [DW_W-1:0]      v;
        int                   sh;
        e  = f[30:23];
        m  = {40'h0000000000, 1'b1, f[22:0]};
        sh = int'(e) - FLT_BIAS;
        if (sh < 0) begin
            v = '0;
        end else if (sh > 30) begin
            v = INT_INDEF;
        end else begin
            v = (sh >= 23) ? 32'(m << (sh - 23)) : 32'(m >> (23 - sh));
        end
        f2i = (f[31] && v != INT_INDEF) ? 32'(-v) : v;
    endfunction : f2i

    // signed 32-bit integer to single precision, truncating
    function automatic logic [DW_W-1:0] i2f(input logic [DW_W-1:0] x);
        logic [DW_W-1:0] a;
        logic [DW_W-1:0] n;
        int              p;
        a = x[31] ? 32'(-x) : x;
        p = 0;
        for (int i = 0; i < DW_W; i++) begin
            if (a[i]) p = i;
        end
        n = a << (31 - p);
        i2f = (a == '0) ? '0 : {x[31], 8'(p + FLT_BIAS), n[30:8]};
    endfunction : i2f

    // double precision to signed 32-bit integer, truncating
    function automatic logic [DW_W-1:0] d2i(input logic [63:0] d);
        logic [63:0]     m;
        logic [DW_W-1:0] v;
        int              sh;
        m  = {11'h000, 1'b1, d[51:0]};
        sh = int'(d[62:52]) - DBL_BIAS;
        if (sh < 0) begin
            v = '0;
        end else if (sh > 30) begin
            v = INT_INDEF;
        end else begin
            v = 32'(m >> (DBL_MANT_W - sh));
        end
        d2i = (d[63] && v != INT_INDEF) ? 32'(-v) : v;
    endfunction : d2i

    // signed 32-bit integer to double precision, exact
    function automatic logic [63:0] i2d(input logic [DW_W-1:0] x);
        logic [DW_W-1:0] a;
        logic [63:0]     n;
        int              p;
        a = x[31] ? 32'(-x) : x;
        p = 0;
        for (int i = 0; i < DW_W; i++) begin
            if (a[i]) p = i;
        end
        n = {32'h00000000, a} << (DBL_MANT_W - p);
        i2d = (a == '0) ? '0 : {x[31], 11'(p + DBL_BIAS), n[51:0]};
    endfunction : i2d

    wire logic [NARROW_W-1:0] dst_lo = req.dst[NARROW_W-1:0];
    wire logic [NARROW_W-1:0] dst_hi = req.dst[WIDE_W-1:NARROW_W];
    wire logic [NARROW_W-1:0] src_lo = req.src[NARROW_W-1:0];
    wire logic [NARROW_W-1:0] src_hi = req.src[WIDE_W-1:NARROW_W];
    wire logic [IMM_W-1:0]    imm    = req.select_immediate;

    // insert word: only bits 1:0 of the immediate are used
    wire logic [SEL_W-1:0] ins_idx = imm[SEL_W-1:0];
    logic [NARROW_W-1:0]   insert_res;
    always_comb begin
        insert_res = dst_lo;
        insert_res[ins_idx*LANE_W +: LANE_W] = req.int_src[LANE_W-1:0];
    end

    // byte sign mask
    logic [WIDE_MASK-1:0] sign_bits;
    always_comb begin
        for (int i = 0; i < WIDE_MASK; i++) begin
            sign_bits[i] = req.src[i*BYTE_W + BYTE_W - 1];
        end
    end
    wire logic [INT_W-1:0] mask_narrow = {24'h000000, sign_bits[NARROW_MASK-1:0]};
    wire logic [INT_W-1:0] mask_wide   = {16'h0000, sign_bits};

    // word and half shuffles
    wire logic [NARROW_W-1:0] word_shuf = shuffle4w(src_lo, imm);
    wire logic [WIDE_W-1:0]   low_half  = {src_hi, shuffle4w(src_lo, imm)};
    wire logic [WIDE_W-1:0]   high_half = {shuffle4w(src_hi, imm), src_lo};

    // dword shuffle, same two-bit field layout
    logic [WIDE_W-1:0] dword_res;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            dword_res[i*DW_W +: DW_W] = req.src[imm[i*SEL_W +: SEL_W]*DW_W +: DW_W];
        end
    end

    // byte shuffle: control bytes in dst, index limited to 16 bytes, bit 7 zeroes
    logic [WIDE_W-1:0] byte_res;
    always_comb begin
        for (int i = 0; i < WIDE_MASK; i++) begin
            byte_res[i*BYTE_W +: BYTE_W] = req.dst[i*BYTE_W + BYTE_W - 1] ? 8'h00 :
                req.src[req.dst[i*BYTE_W +: 4]*BYTE_W +: BYTE_W];
        end
    end

    // conversions
    logic [WIDE_W-1:0] f2i_res;
    logic [WIDE_W-1:0] i2f_res;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            f2i_res[i*DW_W +: DW_W] = f2i(req.src[i*DW_W +: DW_W]);
            i2f_res[i*DW_W +: DW_W] = i2f(req.src[i*DW_W +: DW_W]);
        end
    end
    wire logic [WIDE_W-1:0] d2i_res = {64'h0000000000000000, d2i(src_hi), d2i(src_lo)};
    wire logic [WIDE_W-1:0] i2d_res = {i2d(req.src[63:32]), i2d(req.src[31:0])};

    // result selection
    result_t sel;
    always_comb begin
        sel = '0;
        case (req.op)
            OP_INSERT_WORD:            sel.vec = {dst_hi, insert_res};
            OP_BYTE_SIGN_MASK_NARROW:  sel.int_res = mask_narrow;
            OP_BYTE_SIGN_MASK_WIDE:    sel.int_res = mask_wide;
            OP_WORD_SHUFFLE:           sel.vec = {dst_hi, word_shuf};
            OP_LOW_HALF_WORD_SHUFFLE:  sel.vec = low_half;
            OP_HIGH_HALF_WORD_SHUFFLE: sel.vec = high_half;
            OP_DWORD_SHUFFLE:          sel.vec = dword_res;
            OP_BYTE_SHUFFLE:           sel.vec = byte_res;
            OP_LOW_QWORD_INTERLEAVE:   sel.vec = {src_lo, dst_lo};
            OP_HIGH_QWORD_INTERLEAVE:  sel.vec = {src_hi, dst_hi};
            OP_NARROW_TO_WIDE_MOVE:    sel.vec = {64'h0000000000000000, src_lo};
            OP_WIDE_TO_NARROW_MOVE:    sel.vec = {dst_hi, src_lo};
            OP_FLOAT_TO_INT:           sel.vec = f2i_res;
            OP_INT_TO_FLOAT:           sel.vec = i2f_res;
            OP_DOUBLE_TO_INT:          sel.vec = d2i_res;
            OP_INT_TO_DOUBLE:          sel.vec = i2d_res;
            default:                   sel = '0;
        endcase
    end

    wire logic [RES_W-1:0] stage_in = {req_valid, sel};
    logic      [RES_W-1:0] stage_out;

    result_stage #(
        .DATA_W (RES_W)
    ) u_stage (
        .clk     (clk),
        .rstn    (rstn),
        .wr_data (stage_in),
        .rd_data (stage_out)
    );

    assign res_valid = stage_out[RES_W-1];
    assign res       = stage_out[RES_W-2:0];
endmodule : simd_word_permute_unit

// file: verilog/permute_pkg.sv
// shared types and constants for the word permute datapath
package permute_pkg;
    localparam int WIDE_W      = 128;
    localparam int NARROW_W    = 64;
    localparam int INT_W       = 32;
    localparam int IMM_W       = 8;
    localparam int LANE_W      = 16;
    localparam int DW_W        = 32;
    localparam int BYTE_W      = 8;
    localparam int SEL_W       = 2;
    localparam int NARROW_MASK = 8;
    localparam int WIDE_MASK   = 16;
    localparam int FLT_EXP_W   = 8;
    localparam int FLT_BIAS    = 127;
    localparam int DBL_BIAS    = 1023;
    localparam int DBL_MANT_W  = 52;
    localparam int LATENCY     = 1;
    localparam logic [31:0] INT_INDEF = 32'h80000000;

    typedef enum logic [4:0] {
        OP_INSERT_WORD,
        OP_BYTE_SIGN_MASK_NARROW,
        OP_BYTE_SIGN_MASK_WIDE,
        OP_WORD_SHUFFLE,
        OP_LOW_HALF_WORD_SHUFFLE,
        OP_HIGH_HALF_WORD_SHUFFLE,
        OP_DWORD_SHUFFLE,
        OP_BYTE_SHUFFLE,
        OP_LOW_QWORD_INTERLEAVE,
        OP_HIGH_QWORD_INTERLEAVE,
        OP_NARROW_TO_WIDE_MOVE,
        OP_WIDE_TO_NARROW_MOVE,
        OP_FLOAT_TO_INT,
        OP_INT_TO_FLOAT,
        OP_DOUBLE_TO_INT,
        OP_INT_TO_DOUBLE
    } op_t;

    typedef struct packed {
        op_t                 op;
        logic [WIDE_W-1:0]   dst;
        logic [WIDE_W-1:0]   src;
        logic [INT_W-1:0]    int_src;
        logic [IMM_W-1:0]    select_immediate;
    } request_t;

    typedef struct packed {
        logic [WIDE_W-1:0]   vec;
        logic [INT_W-1:0]    int_res;
    } result_t;
endpackage : permute_pkg

// file: verilog/result_stage.sv
// output register stage holding one result word
`timescale 1ns/1ps
module result_stage
    import permute_pkg::*;
#(
    parameter int DATA_W = WIDE_W + INT_W + 1
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic      [DATA_W-1:0] rd_data
);
    if (DATA_W < 1) begin : g_bad_width
        $error("result_stage: DATA_W must be positive");
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data <= '0;
        end else begin
            rd_data <= wr_data;
        end
    end
endmodule : result_stage

// file: verif/permute_checker_sva.sv
// port assertions for the permute datapath
`timescale 1ns/1ps
module permute_checker
    import permute_pkg::*;
(
    input wire logic     clk,
    input wire logic     rstn,
    input wire logic     req_valid,
    input wire request_t req,
    input wire logic     res_valid,
    input wire result_t  res
);
    logic [63:0] ins_w;
    logic        go;
    assign go = req_valid;
    always_comb begin
        ins_w = req.dst[63:0];
        ins_w[{req.select_immediate[1:0], 4'h0} +: 16] = req.int_src[15:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_lat; go |=> res_valid; endproperty
    a_lat: assert property (p_lat) else $error("no result after request");
    property p_idle; !go |=> !res_valid; endproperty
    a_idle: assert property (p_idle) else $error("result without request");
    property p_ins; go && req.op == OP_INSERT_WORD |=> res.vec == {$past(req.dst[127:64]), $past(ins_w)}; endproperty
    a_ins: assert property (p_ins) else $error("insert wrong");
    property p_mn; go && req.op == OP_BYTE_SIGN_MASK_NARROW ##1 1'b1 |-> res.int_res[31:8] == 24'h0
        && res.int_res[0] == $past(req.src[7]) && res.int_res[7] == $past(req.src[63]); endproperty
    a_mn: assert property (p_mn) else $error("narrow mask wrong");
    property p_mw; go && req.op == OP_BYTE_SIGN_MASK_WIDE |=> res.int_res[31:16] == 16'h0
        && res.int_res[15] == $past(req.src[127]) && res.int_res[8] == $past(req.src[71]); endproperty
    a_mw: assert property (p_mw) else $error("wide mask wrong");
    property p_hh; go && req.op == OP_HIGH_HALF_WORD_SHUFFLE |=> res.vec[63:0] == $past(req.src[63:0]); endproperty
    a_hh: assert property (p_hh) else $error("half pass wrong");
    property p_il; go && req.op == OP_LOW_QWORD_INTERLEAVE |=> res.vec == {$past(req.src[63:0]), $past(req.dst[63:0])};
    endproperty
    a_il: assert property (p_il) else $error("interleave wrong");
    property p_nw; go && req.op == OP_NARROW_TO_WIDE_MOVE |=> res.vec == {64'h0, $past(req.src[63:0])}; endproperty
    a_nw: assert property (p_nw) else $error("widen move wrong");
    property p_wn; go && req.op == OP_WIDE_TO_NARROW_MOVE |=> res.vec[63:0] == $past(req.src[63:0]); endproperty
    a_wn: assert property (p_wn) else $error("narrow move wrong");
    c_ins: cover property (go && req.op == OP_INSERT_WORD);
    c_mw: cover property (go && req.op == OP_BYTE_SIGN_MASK_WIDE);
    c_b2b: cover property (go ##1 go ##1 go);
endmodule : permute_checker
bind simd_word_permute_unit permute_checker permute_checker_inst (
    .clk       (clk),
    .rstn      (rstn),
    .req_valid (req_valid),
    .req       (req),
    .res_valid (res_valid),
    .res       (res)
);

// file: verif/regfile_model.sv
// writeback sink standing for the register files
`timescale 1ns/1ps
module regfile_model
    import permute_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    rstn,
    input  wire logic    res_valid,
    input  wire result_t res,
    output logic [7:0]   wr_count_q,
    output result_t      last_wr_q
);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_count_q <= 8'h00;
        end else if (res_valid) begin
            wr_count_q <= wr_count_q + 8'h01;
            last_wr_q  <= res;
        end
    end
endmodule : regfile_model

// file: verif/tb.sv
// self-checking bench for the permute datapath
`timescale 1ns/1ps
module tb;
    import permute_pkg::*;
    typedef struct {op_t op; logic [7:0] imm; logic [127:0] src; logic [127:0] vec; logic [31:0] ir;} row_t;
    localparam int N = 17;
    localparam logic [127:0] S = 128'h8F0E0D0C8B0A09088706050483020100;
    localparam logic [127:0] D = 128'hDDDDCCCCBBBBAAAA9999888877776666;
    localparam logic [31:0]  I = 32'h12345678;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       req_valid = 1'b0;
    request_t   req = '0;
    logic       res_valid;
    result_t    res;
    logic [7:0] wr_count_q;
    result_t    last_wr_q;
    int         num_errors = 0;
    int         n_checks = 0;
    row_t rows [N] = '{
        '{OP_INSERT_WORD, 8'hFE, S, 128'hDDDDCCCCBBBBAAAA9999567877776666, 32'h0},
        '{OP_BYTE_SIGN_MASK_NARROW, 8'h00, S, 128'h0, 32'h88},
        '{OP_BYTE_SIGN_MASK_WIDE, 8'h00, S, 128'h0, 32'h8888},
        '{OP_WORD_SHUFFLE, 8'h1B, S, 128'hDDDDCCCCBBBBAAAA0100830205048706, 32'h0},
        '{OP_LOW_HALF_WORD_SHUFFLE, 8'h1B, S, 128'h8F0E0D0C8B0A09080100830205048706, 32'h0},
        '{OP_HIGH_HALF_WORD_SHUFFLE, 8'h1B, S, 128'h09088B0A0D0C8F0E8706050483020100, 32'h0},
        '{OP_DWORD_SHUFFLE, 8'h1B, S, 128'h83020100870605048B0A09088F0E0D0C, 32'h0},
        '{OP_DWORD_SHUFFLE, 8'hAA, S, 128'h8B0A09088B0A09088B0A09088B0A0908, 32'h0},
        '{OP_BYTE_SHUFFLE, 8'h00, S, 128'h87870606, 32'h0},
        '{OP_LOW_QWORD_INTERLEAVE, 8'h00, S, 128'h87060504830201009999888877776666, 32'h0},
        '{OP_HIGH_QWORD_INTERLEAVE, 8'h00, S, 128'h8F0E0D0C8B0A0908DDDDCCCCBBBBAAAA, 32'h0},
        '{OP_NARROW_TO_WIDE_MOVE, 8'h00, S, 128'h8706050483020100, 32'h0},
        '{OP_WIDE_TO_NARROW_MOVE, 8'h00, S, 128'hDDDDCCCCBBBBAAAA8706050483020100, 32'h0},
        '{OP_FLOAT_TO_INT, 8'h00, 128'h501502F942C80000C02000003F800000, 128'h8000000000000064FFFFFFFE00000001, 32'h0},
        '{OP_INT_TO_FLOAT, 8'h00, 128'h0000000000000064FFFFFFFE00000001, 128'h0000000042C80000C00000003F800000, 32'h0},
        '{OP_DOUBLE_TO_INT, 8'h00, 128'h4000000000000000BFF8000000000000, 128'h00000002FFFFFFFF, 32'h0},
        '{OP_INT_TO_DOUBLE, 8'h00, 128'h00000002FFFFFFFF, 128'h4000000000000000BFF0000000000000, 32'h0}};
    simd_word_permute_unit simd_word_permute_unit_inst (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
        .res_valid(res_valid), .res(res));
    regfile_model regfile_model_inst (.clk(clk), .rstn(rstn), .res_valid(res_valid), .res(res),
        .wr_count_q(wr_count_q), .last_wr_q(last_wr_q));
    always #5 clk = ~clk;
    task automatic chk_vec(input string what, input logic [127:0] exp, input logic [127:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_vec
    task automatic chk_flag(input string what, input logic exp, input logic got);
        chk_vec(what, {127'h0, exp}, {127'h0, got});
    endtask : chk_flag
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i <= N; i++) begin
            @(posedge clk);
            req_valid <= (i < N);
            if (i < N) begin
                req <= '{rows[i].op, D, rows[i].src, I, rows[i].imm};
            end
            #1;
            if (i > 0) begin
                chk_flag("res_valid", 1'b1, res_valid);
                chk_vec("vec", rows[i-1].vec, res.vec);
                chk_vec("int_res", {96'h0, rows[i-1].ir}, {96'h0, res.int_res});
                if (i > 1) begin
                    chk_vec("wb", rows[i-2].vec, last_wr_q.vec);
                end
            end
        end
        @(posedge clk);
        #1;
        chk_flag("idle res_valid", 1'b0, res_valid);
        chk_vec("writes", {120'h0, 8'h11}, {120'h0, wr_count_q});
        chk_vec("last write", rows[N-1].vec, last_wr_q.vec);
        @(posedge clk);
        req_valid <= 1'b1;
        rstn <= 1'b0;
        @(posedge clk);
        #1;
        chk_flag("reset res_valid", 1'b0, res_valid);
        chk_vec("reset vec", 128'h0, res.vec);
        @(posedge clk);
        rstn <= 1'b1;
        req <= '{OP_INSERT_WORD, D, S, I, 8'h03};
        @(posedge clk);
        #1;
        chk_vec("insert top", 128'hDDDDCCCCBBBBAAAA5678888877776666, res.vec);
        end_sim();
    end
endmodule : tb
